// ==== inc/urw_pkg.sv ====
/*
  Package for the serial port receiver-wakeup, flag and loop block: register indices,
  field positions, reset values, state encodings and bit-time counts.
  Assumes a byte-wide register port with a 3-bit address and a 100 MHz system clock.
*/
package urw_pkg;

  // ****************************************************************
  // Register indices on the 3-bit port
  // ****************************************************************
  localparam logic [2:0] REG_BAUD_HI = 3'h0, REG_BAUD_LO = 3'h1, REG_CTRL1 = 3'h2, REG_CTRL2 = 3'h3;
  localparam logic [2:0] REG_STAT1 = 3'h4, REG_STAT2 = 3'h5, REG_CTRL3 = 3'h6, REG_DATA = 3'h7;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BH_LBKDIE = 7, BH_EDGIE = 6;
  localparam int C1_LOOP = 7, C1_RX_SOURCE_SELECT = 5, C1_WLS = 4, C1_WAKE = 3, C1_ILT = 2, C1_PE = 1, C1_PT = 0;
  localparam int C2_TIE = 7, C2_TX_DONE_IRQ_ENABLE = 6, C2_RIE = 5, C2_ILIE = 4, C2_TE = 3, C2_RE = 2, C2_SLEEP = 1, C2_SBK = 0;
  localparam int S1_TX_BUFFER_EMPTY_FLAG = 7, S1_TC = 6, S1_RX_BUFFER_FULL_FLAG = 5, S1_IDLE = 4, S1_OR = 3, S1_NF = 2, S1_FE = 1, S1_PF = 0;
  localparam int S2_LBKD = 7, S2_EDGE = 6, S2_IDLE_DURING_SLEEP_FLAGGING = 3, S2_BRK13 = 2, S2_RAF = 0;
  localparam int C3_R8 = 7, C3_T8 = 6, C3_SINGLE_WIRE_DIRECTION = 5, C3_ORIE = 3, C3_NEIE = 2, C3_FEIE = 1, C3_PEIE = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [12:0] BAUD_RST = 13'h0004;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT1_RST = 8'hc0;

  // ****************************************************************
  // Bit-time counts, in bit times or 16x ticks
  // ****************************************************************
  localparam logic [3:0] TICKS_LAST = 4'hf;
  localparam logic [3:0] RT_S1 = 4'h7, RT_S2 = 4'h8, RT_S3 = 4'h9;
  localparam logic [3:0] CHAR_BITS_8 = 4'ha, CHAR_BITS_9 = 4'hb;
  localparam logic [3:0] BRK_10 = 4'ha, BRK_11 = 4'hb, BRK_13 = 4'hd, BRK_14 = 4'he;
  localparam logic [7:0] IDLE_TICKS_8 = 8'ha0, IDLE_TICKS_9 = 8'hb0;

  // ****************************************************************
  // Receiver states, one-hot
  // ****************************************************************
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } urw_rx_state_t;

endpackage

// ==== logic/urw_sync3.sv ====
/*
  Three-stage synchroniser for one pin input.
  Assumes the input is asynchronous to sys_clk; output changes once stages two and three agree.
*/
`timescale 1ns/100ps
module urw_sync3 (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Pin and result
  input wire logic pin_i,
  output logic level_q
);

  logic s1_q, s2_q, s3_q;

  // Chain; first stage is read only by the second
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a level only when two stages agree
  always_ff @(posedge sys_clk) begin
    if (!rstn) level_q <= 1'b1;
    else if (s2_q == s3_q) level_q <= s3_q;
  end

endmodule // urw_sync3

// ==== logic/urw_baud.sv ====
/*
  Baud divider: one-cycle pulse at sixteen times the bit rate.
  Assumes divisor is steady while in use; zero stops the ticks.
*/
`timescale 1ns/100ps
module urw_baud #(
  parameter int DIV_W = 13
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Control
  input wire logic run,
  input wire logic [DIV_W-1:0] divisor,
  // Tick out
  output logic tick_q
);

  logic [DIV_W-1:0] cnt_q;

  // Count up to one below the divisor; frozen while halted
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (run && divisor != '0) begin
        if (cnt_q >= divisor - DIV_W'(1)) begin
          cnt_q <= '0;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + DIV_W'(1);
        end
      end
    end
  end

endmodule // urw_baud

// ==== logic/urw_core.sv ====
/*
  Serial port core: transmitter, receiver with sleep and wakeup, status flags,
  three interrupt requests, stop freeze, loop and single-wire routing.
  Assumes a one-cycle strobe register port and pins synchronised here.
*/
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/100ps
module urw_core (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Serial pins
  input wire logic rxd_i,
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe,
  output logic rxd_in_use,
  // System
  input wire logic stop_mode,
  output logic stop_wake,
  output logic irq_tx,
  output logic irq_rx,
  output logic irq_err
);

  // ****************************************************************
  // Registers and shared signals
  // ****************************************************************
  logic [12:0] baud_q;
  logic [7:0] ctrl1_q, ctrl2_q, ctrl3_q;
  logic lbkdie_q, edgie_q, idle_during_sleep_flagging_q, brk13_q;
  logic tx_buffer_empty_flag_q, tc_q, rx_buffer_full_flag_q, idle_q, or_q, nf_q, fe_q, pf_q, lbkd_q, edge_q;
  logic [7:0] rx_data_q, tx_buf_q;
  logic r8_q;
  logic [5:0] snap_q;
  logic baud_tick, tick, run, rx_pin, tx_pin, rx_line, tx_line;
  logic wr_c2, wr_data, rd_data, rd_stat1;
  logic wls, re, te, sleep;
  assign wls = ctrl1_q[urw_pkg::C1_WLS];
  assign re = ctrl2_q[urw_pkg::C2_RE];
  assign te = ctrl2_q[urw_pkg::C2_TE];
  assign sleep = ctrl2_q[urw_pkg::C2_SLEEP];
  assign wr_c2 = reg_wr && reg_addr == urw_pkg::REG_CTRL2;
  assign wr_data = reg_wr && reg_addr == urw_pkg::REG_DATA;
  assign rd_data = reg_rd && reg_addr == urw_pkg::REG_DATA;
  assign rd_stat1 = reg_rd && reg_addr == urw_pkg::REG_STAT1;
  // Halting ticks freezes both shifters with all state kept
  assign run = !stop_mode;
  // Gate the registered tick too, so no shift slips in on the stop edge
  assign tick = baud_tick && run;

  urw_sync3 u_rx_sync (.sys_clk(sys_clk), .rstn(rstn), .pin_i(rxd_i), .level_q(rx_pin));
  urw_sync3 u_tx_sync (.sys_clk(sys_clk), .rstn(rstn), .pin_i(txd_i), .level_q(tx_pin));
  urw_baud #(.DIV_W(13)) u_baud (.sys_clk(sys_clk), .rstn(rstn), .run(run), .divisor(baud_q), .tick_q(baud_tick));

  // ****************************************************************
  // Pin routing
  // ****************************************************************
  // Receiver source: own pin, transmitter, or shared transmit wire
  always_comb begin
    if (!ctrl1_q[urw_pkg::C1_LOOP]) rx_line = rx_pin;
    else if (!ctrl1_q[urw_pkg::C1_RX_SOURCE_SELECT]) rx_line = tx_line;
    else if (ctrl3_q[urw_pkg::C3_SINGLE_WIRE_DIRECTION]) rx_line = tx_line;
    else rx_line = tx_pin;
  end
  assign rxd_in_use = re && !ctrl1_q[urw_pkg::C1_LOOP];
  assign txd_o = tx_line;

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Plain control registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      baud_q <= urw_pkg::BAUD_RST;
      ctrl1_q <= urw_pkg::CTRL_RST;
      ctrl3_q <= urw_pkg::CTRL_RST;
      {lbkdie_q, edgie_q, idle_during_sleep_flagging_q, brk13_q} <= 4'h0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        urw_pkg::REG_BAUD_HI: begin
          baud_q[12:8] <= reg_wdata[4:0];
          lbkdie_q <= reg_wdata[urw_pkg::BH_LBKDIE];
          edgie_q <= reg_wdata[urw_pkg::BH_EDGIE];
        end
        urw_pkg::REG_BAUD_LO: baud_q[7:0] <= reg_wdata;
        urw_pkg::REG_CTRL1: ctrl1_q <= reg_wdata;
        urw_pkg::REG_STAT2: begin
          idle_during_sleep_flagging_q <= reg_wdata[urw_pkg::S2_IDLE_DURING_SLEEP_FLAGGING];
          brk13_q <= reg_wdata[urw_pkg::S2_BRK13];
        end
        // Ninth transmit bit is held until rewritten
        urw_pkg::REG_CTRL3: ctrl3_q <= {1'b0, reg_wdata[6:0]};
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  logic [3:0] tx_tick_q, tx_left_q;
  logic [13:0] tx_sh_q;
  logic te_d1_q, pre_pend_q, brk_pend_q, tx_bit, tx_free, tx_load;
  logic [13:0] tx_frame;
  logic [3:0] brk_len;
  assign tx_bit = tick && tx_tick_q == urw_pkg::TICKS_LAST;
  assign tx_free = tx_left_q <= 4'h1;
  assign tx_load = tx_bit && tx_free && te && !tx_buffer_empty_flag_q;
  assign tx_line = (tx_left_q != 4'h0) ? tx_sh_q[0] : 1'b1;
  // Transmit pin released for single-wire receive, and while disabled with no frame left
  assign txd_oe = (te || tx_left_q != 4'h0) &&
                  !(ctrl1_q[urw_pkg::C1_LOOP] && ctrl1_q[urw_pkg::C1_RX_SOURCE_SELECT] && !ctrl3_q[urw_pkg::C3_SINGLE_WIRE_DIRECTION]);

  // Data frame, parity taking the top data bit when enabled
  always_comb begin
    logic par;
    par = ctrl1_q[urw_pkg::C1_PT];
    if (wls) begin
      par = par ^ (^tx_buf_q);
      tx_frame = {4'hf, ctrl1_q[urw_pkg::C1_PE] ? par : ctrl3_q[urw_pkg::C3_T8], tx_buf_q, 1'b0};
    end else begin
      par = par ^ (^tx_buf_q[6:0]);
      tx_frame = {5'h1f, ctrl1_q[urw_pkg::C1_PE] ? par : tx_buf_q[7], tx_buf_q[6:0], 1'b0};
    end
    unique case ({brk13_q, wls})
      2'b00: brk_len = urw_pkg::BRK_10;
      2'b01: brk_len = urw_pkg::BRK_11;
      2'b10: brk_len = urw_pkg::BRK_13;
      default: brk_len = urw_pkg::BRK_14;
    endcase
  end

  // Bit timing and shifter; data first, then break, then preamble
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tx_tick_q <= 4'h0;
      tx_left_q <= 4'h0;
      tx_sh_q <= 14'h3fff;
    end else if (tick) begin
      tx_tick_q <= tx_tick_q + 4'h1;
      if (tx_bit) begin
        if (!tx_free) begin
          tx_sh_q <= {1'b1, tx_sh_q[13:1]};
          tx_left_q <= tx_left_q - 4'h1;
        end else if (tx_load) begin
          // Ninth bit copied in the same transfer as the byte
          tx_sh_q <= tx_frame;
          tx_left_q <= wls ? urw_pkg::CHAR_BITS_9 : urw_pkg::CHAR_BITS_8;
        end else if (brk_pend_q) begin
          tx_sh_q <= 14'h0000;
          tx_left_q <= brk_len;
        end else if (pre_pend_q) begin
          tx_sh_q <= 14'h3fff;
          tx_left_q <= wls ? urw_pkg::CHAR_BITS_9 : urw_pkg::CHAR_BITS_8;
        end else begin
          tx_left_q <= 4'h0;
        end
      end
    end
  end

  // Queued preamble on enable, queued break on send-break
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      te_d1_q <= 1'b0;
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else begin
      te_d1_q <= te;
      if (te && !te_d1_q) pre_pend_q <= 1'b1;
      else if (tx_bit && tx_free && !tx_load && !brk_pend_q) pre_pend_q <= 1'b0;
      if (wr_c2 && reg_wdata[urw_pkg::C2_SBK]) brk_pend_q <= 1'b1;
      else if (tx_bit && tx_free && !tx_load) brk_pend_q <= ctrl2_q[urw_pkg::C2_SBK];
    end
  end

  // Buffer empty and transmit complete flags
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tx_buffer_empty_flag_q <= urw_pkg::STAT1_RST[urw_pkg::S1_TX_BUFFER_EMPTY_FLAG];
      tc_q <= urw_pkg::STAT1_RST[urw_pkg::S1_TC];
      tx_buf_q <= 8'h00;
    end else begin
      if (wr_data) tx_buf_q <= reg_wdata;
      if (tx_load) tx_buffer_empty_flag_q <= 1'b1;
      else if (wr_data) tx_buffer_empty_flag_q <= 1'b0;
      // Complete only once nothing is queued and the line is idle
      if (tx_bit && tx_free && !tx_load && !brk_pend_q && !pre_pend_q && tx_left_q != 4'h0) begin
        tc_q <= 1'b1;
      end else if (wr_data || (te && !te_d1_q) || (wr_c2 && reg_wdata[urw_pkg::C2_SBK])) begin
        tc_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  urw_pkg::urw_rx_state_t rx_st_q;
  logic [3:0] rt_q, bit_idx_q;
  logic [1:0] smp_q;
  logic [8:0] rx_sh_q;
  logic [7:0] idle_cnt_q, idle_need;
  logic prev_q, noise_acc_q, idle_arm_q;
  logic maj, noisy, at_eval, msb_bit, done_ok, done_bad, ch_done, idle_hit, fe_bit;
  logic [3:0] msb_idx;
  assign maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & rx_line) | (smp_q[1] & rx_line);
  assign noisy = (smp_q[0] | smp_q[1] | rx_line) & !(smp_q[0] & smp_q[1] & rx_line);
  assign at_eval = tick && re && rt_q == urw_pkg::RT_S3;
  assign msb_idx = wls ? 4'h8 : 4'h7;
  assign msb_bit = at_eval && rx_st_q == urw_pkg::RX_DATA && bit_idx_q == msb_idx;
  assign ch_done = at_eval && rx_st_q == urw_pkg::RX_STOP;
  assign fe_bit = !maj;
  // Sleeping receiver produces no character flags
  assign done_ok = ch_done && !sleep && !rx_buffer_full_flag_q;
  assign done_bad = ch_done && !sleep && rx_buffer_full_flag_q;
  assign idle_need = wls ? urw_pkg::IDLE_TICKS_9 : urw_pkg::IDLE_TICKS_8;
  assign idle_hit = tick && re && rx_line && idle_cnt_q == idle_need - 8'h01;

  // Frame sequencer on the 16x tick, samples at the bit middle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rx_st_q <= urw_pkg::RX_IDLE;
      rt_q <= 4'h0;
      bit_idx_q <= 4'h0;
      smp_q <= 2'h3;
      prev_q <= 1'b1;
      rx_sh_q <= 9'h000;
      noise_acc_q <= 1'b0;
    end else if (tick && !re) begin
      rx_st_q <= urw_pkg::RX_IDLE;
      prev_q <= 1'b1;
    end else if (tick) begin
      prev_q <= rx_line;
      rt_q <= rt_q + 4'h1;
      if (rt_q == urw_pkg::RT_S1 || rt_q == urw_pkg::RT_S2) smp_q <= {rx_line, smp_q[1]};
      unique case (rx_st_q)
        urw_pkg::RX_IDLE: begin
          if (prev_q && !rx_line) begin
            rx_st_q <= urw_pkg::RX_START;
            rt_q <= 4'h1;
          end
        end
        urw_pkg::RX_START: begin
          if (rt_q == urw_pkg::RT_S3) begin
            rx_st_q <= maj ? urw_pkg::RX_IDLE : urw_pkg::RX_DATA;
            noise_acc_q <= noisy;
            bit_idx_q <= 4'h0;
          end
        end
        urw_pkg::RX_DATA: begin
          if (rt_q == urw_pkg::RT_S3) begin
            rx_sh_q[bit_idx_q] <= maj;
            noise_acc_q <= noise_acc_q | noisy;
            bit_idx_q <= bit_idx_q + 4'h1;
            if (bit_idx_q == msb_idx) rx_st_q <= urw_pkg::RX_STOP;
          end
        end
        urw_pkg::RX_STOP: begin
          // Back to hunting at the stop middle, ready for a close start
          if (rt_q == urw_pkg::RT_S3) rx_st_q <= urw_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Idle timer in 16x ticks; low line restarts it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      idle_cnt_q <= 8'h00;
    end else if (tick) begin
      if (!re || !rx_line) idle_cnt_q <= 8'h00;
      else if (ctrl1_q[urw_pkg::C1_ILT] && rx_st_q != urw_pkg::RX_IDLE) idle_cnt_q <= 8'h00;
      else if (idle_cnt_q != idle_need) idle_cnt_q <= idle_cnt_q + 8'h01;
    end
  end

  // Sleep bit: software writes it, wakeup events clear it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl2_q <= urw_pkg::CTRL_RST;
    end else if (wr_c2) begin
      ctrl2_q <= reg_wdata;
    end else if (sleep && !ctrl1_q[urw_pkg::C1_WAKE] && idle_hit) begin
      ctrl2_q[urw_pkg::C2_SLEEP] <= 1'b0;
    end else if (sleep && ctrl1_q[urw_pkg::C1_WAKE] && msb_bit && maj) begin
      // Woken before the stop bit so this character is kept
      ctrl2_q[urw_pkg::C2_SLEEP] <= 1'b0;
    end
  end

  // ****************************************************************
  // Receive flags and data buffer
  // ****************************************************************
  logic clr_rx;
  assign clr_rx = rd_data;

  // Status read snapshots the flags that a data read then clears
  always_ff @(posedge sys_clk) begin
    if (!rstn) snap_q <= 6'h00;
    else if (rd_stat1) snap_q <= {rx_buffer_full_flag_q, idle_q, or_q, nf_q, fe_q, pf_q};
    else if (rd_data) snap_q <= 6'h00;
  end

  // Character flags; a setting event wins over a clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      {rx_buffer_full_flag_q, or_q, nf_q, fe_q, pf_q, lbkd_q, r8_q} <= 7'h00;
      rx_data_q <= 8'h00;
    end else begin
      if (done_ok) begin
        rx_buffer_full_flag_q <= 1'b1;
        rx_data_q <= rx_sh_q[7:0];
        r8_q <= wls && rx_sh_q[8];
        // Errors ride with the character that carries them
        nf_q <= noise_acc_q | noisy;
        fe_q <= fe_bit;
        pf_q <= ctrl1_q[urw_pkg::C1_PE] &&
                (((wls ? ^rx_sh_q : ^rx_sh_q[7:0]) ^ ctrl1_q[urw_pkg::C1_PT]) != 1'b0);
      end else if (clr_rx) begin
        rx_buffer_full_flag_q <= rx_buffer_full_flag_q & !snap_q[5];
        nf_q <= nf_q & !snap_q[2];
        fe_q <= fe_q & !snap_q[1];
        pf_q <= pf_q & !snap_q[0];
      end
      // Overrun keeps the old data, drops the new errors
      if (done_bad) or_q <= 1'b1;
      else if (clr_rx) or_q <= or_q & !snap_q[3];
      if (ch_done && !sleep && fe_bit && rx_sh_q[7:0] == 8'h00 && !(wls && rx_sh_q[8])) lbkd_q <= 1'b1;
      else if (reg_wr && reg_addr == urw_pkg::REG_STAT2 && reg_wdata[urw_pkg::S2_LBKD]) lbkd_q <= 1'b0;
    end
  end

  // Idle flag, armed once per received character
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      idle_q <= 1'b0;
      idle_arm_q <= 1'b0;
    end else begin
      if (done_ok) idle_arm_q <= 1'b1;
      else if (idle_hit) idle_arm_q <= 1'b0;
      if (idle_hit && idle_arm_q && (!sleep || idle_during_sleep_flagging_q)) idle_q <= 1'b1;
      else if (clr_rx && snap_q[4]) idle_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Edge detector, alive in stop as well
  // ****************************************************************
  logic edge_prev_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      edge_prev_q <= 1'b1;
      edge_q <= 1'b0;
    end else begin
      edge_prev_q <= rx_line;
      if (re && edge_prev_q && !rx_line) edge_q <= 1'b1;
      else if (reg_wr && reg_addr == urw_pkg::REG_STAT2 && reg_wdata[urw_pkg::S2_EDGE]) edge_q <= 1'b0;
    end
  end
  assign stop_wake = stop_mode && edge_q && edgie_q;

  // ****************************************************************
  // Interrupt requests
  // ****************************************************************
  assign irq_tx = (tx_buffer_empty_flag_q && ctrl2_q[urw_pkg::C2_TIE]) || (tc_q && ctrl2_q[urw_pkg::C2_TX_DONE_IRQ_ENABLE]);
  assign irq_rx = (rx_buffer_full_flag_q && ctrl2_q[urw_pkg::C2_RIE]) || (idle_q && ctrl2_q[urw_pkg::C2_ILIE]) ||
                  (edge_q && edgie_q) || (lbkd_q && lbkdie_q);
  assign irq_err = (or_q && ctrl3_q[urw_pkg::C3_ORIE]) || (nf_q && ctrl3_q[urw_pkg::C3_NEIE]) ||
                   (fe_q && ctrl3_q[urw_pkg::C3_FEIE]) || (pf_q && ctrl3_q[urw_pkg::C3_PEIE]);

  // ****************************************************************
  // Read data, one cycle after the strobe
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        urw_pkg::REG_BAUD_HI: reg_rdata <= {lbkdie_q, edgie_q, 1'b0, baud_q[12:8]};
        urw_pkg::REG_BAUD_LO: reg_rdata <= baud_q[7:0];
        urw_pkg::REG_CTRL1: reg_rdata <= ctrl1_q;
        urw_pkg::REG_CTRL2: reg_rdata <= ctrl2_q;
        urw_pkg::REG_STAT1: reg_rdata <= {tx_buffer_empty_flag_q, tc_q, rx_buffer_full_flag_q, idle_q, or_q, nf_q, fe_q, pf_q};
        urw_pkg::REG_STAT2: reg_rdata <= {lbkd_q, edge_q, 2'b00, idle_during_sleep_flagging_q, brk13_q, 1'b0,
                                          rx_st_q != urw_pkg::RX_IDLE};
        urw_pkg::REG_CTRL3: reg_rdata <= {r8_q, ctrl3_q[6:0]};
        default: reg_rdata <= rx_data_q;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // urw_core

// ==== testbench/urw_properties.sv ====
/* Port checker for the serial core.
   Assumes a bind onto urw_core and a single clock domain. */
`timescale 1ns/100ps
module urw_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Watched ports
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic txd_o,
  input wire logic rxd_in_use,
  input wire logic stop_mode,
  input wire logic stop_wake,
  input wire logic irq_tx,
  input wire logic irq_rx,
  input wire logic irq_err
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ****
  // Port relations
  // ****
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_wake_in_stop: assert property (stop_wake |-> stop_mode && irq_rx)
    else $error("stop wake without stop or edge request");
  a_stop_freeze: assert property (stop_mode && $past(stop_mode) |-> $stable(txd_o))
    else $error("transmit line moved in stop");
  a_pin_owner: assert property (!$past(reg_wr) |-> $stable(rxd_in_use))
    else $error("pin ownership moved without a write");
  // Requests drop only through software, never by hardware on its own
  a_tx_req_held: assert property ($fell(irq_tx) |-> $past(reg_wr))
    else $error("transmit request dropped unprompted");
  a_rx_req_clear: assert property ($fell(irq_rx) |-> $past(reg_rd) || $past(reg_wr))
    else $error("receive request dropped unprompted");
  a_err_req_clear: assert property ($fell(irq_err) |-> $past(reg_rd) || $past(reg_wr))
    else $error("error request dropped unprompted");
  a_wake_drop: assert property ($fell(stop_wake) && stop_mode |-> $past(reg_wr))
    else $error("edge flag cleared without a write");
endmodule // urw_properties

bind urw_core urw_properties i_props (.sys_clk(sys_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .txd_o(txd_o), .rxd_in_use(rxd_in_use), .stop_mode(stop_mode),
  .stop_wake(stop_wake), .irq_tx(irq_tx), .irq_rx(irq_rx), .irq_err(irq_err));

// ==== testbench/urw_remote.sv ====
/* Remote serial transmitter, 8N1, LSB first.
   Assumes the core's reset divisor, so one bit is BIT_CYC clocks. */
`timescale 1ns/100ps
module urw_remote #(
  parameter int BIT_CYC = 64
) (
  // Clock and line
  input wire logic sys_clk,
  output logic line
);
  // Idle level is high, as a released line would rest
  initial line = 1'b1;
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk) line <= f[i];
      repeat (BIT_CYC - 1) @(posedge sys_clk);
    end
  endtask
endmodule // urw_remote

// ==== testbench/tb_top.sv ====
/* Register-level bench for the serial core.
   Assumes the remote model on both pins and the reset divisor of four. */
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, stop_mode = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic line, txd_o, txd_oe, rxd_in_use, stop_wake, irq_tx, irq_rx, irq_err;
  int num_errors = 0, num_checks = 0;
  always #5 sys_clk = ~sys_clk;
  urw_remote i_rem (.sys_clk(sys_clk), .line(line));
  // Shared transmit pin: the core wins while it drives
  urw_core i_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_i(line),
    .txd_i(txd_oe ? txd_o : line), .txd_o(txd_o), .txd_oe(txd_oe), .rxd_in_use(rxd_in_use),
    .stop_mode(stop_mode), .stop_wake(stop_wake), .irq_tx(irq_tx), .irq_rx(irq_rx), .irq_err(irq_err));
  // ****
  // Access tasks
  // ****
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge sys_clk) reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 chk("reg", reg_rdata, e);
  endtask
  task automatic bits(input int n);
    repeat (n * 64) @(posedge sys_clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(urw_pkg::REG_STAT1, 8'hc0);
    // Receive, then status-data clears; idle flags once only
    wr(urw_pkg::REG_CTRL2, 8'h24);
    i_rem.send(8'ha5);
    bits(1);
    chk("irq_rx", irq_rx, 1'b1);
    rd(urw_pkg::REG_STAT1, 8'he0);
    rd(urw_pkg::REG_DATA, 8'ha5);
    bits(12);
    rd(urw_pkg::REG_STAT1, 8'hd0);
    rd(urw_pkg::REG_DATA, 8'ha5);
    bits(12);
    rd(urw_pkg::REG_STAT1, 8'hc0);
    $display("test receive done");
    // Overrun keeps the first character
    wr(urw_pkg::REG_CTRL3, 8'h08);
    i_rem.send(8'h11);
    i_rem.send(8'h22);
    bits(1);
    chk("irq_err", irq_err, 1'b1);
    rd(urw_pkg::REG_STAT1, 8'he8);
    rd(urw_pkg::REG_DATA, 8'h11);
    rd(urw_pkg::REG_STAT1, 8'hc0);
    $display("test overrun done");
    // Address-mark wakeup
    wr(urw_pkg::REG_CTRL1, 8'h08);
    wr(urw_pkg::REG_CTRL2, 8'h26);
    i_rem.send(8'h12);
    bits(1);
    rd(urw_pkg::REG_STAT1, 8'hc0);
    i_rem.send(8'h93);
    bits(1);
    rd(urw_pkg::REG_STAT1, 8'he0);
    rd(urw_pkg::REG_CTRL2, 8'h24);
    rd(urw_pkg::REG_DATA, 8'h93);
    $display("test wakeup done");
    // Loop mode with the pin held low: receiver must ignore it
    wr(urw_pkg::REG_CTRL1, 8'h80);
    @(posedge sys_clk) i_rem.line <= 1'b0;
    wr(urw_pkg::REG_CTRL2, 8'h8c);
    chk("in_use", rxd_in_use, 1'b0);
    chk("irq_tx", irq_tx, 1'b1);
    wr(urw_pkg::REG_DATA, 8'h3c);
    chk("irq_tx", irq_tx, 1'b0);
    bits(38);
    rd(urw_pkg::REG_STAT1, 8'hf0);
    chk("txd_o", txd_o, 1'b1);
    rd(urw_pkg::REG_DATA, 8'h3c);
    // Nine-bit character through the loop, ninth bit written first
    wr(urw_pkg::REG_CTRL1, 8'h90);
    wr(urw_pkg::REG_CTRL3, 8'h48);
    wr(urw_pkg::REG_DATA, 8'h5a);
    bits(16);
    rd(urw_pkg::REG_STAT1, 8'he0);
    rd(urw_pkg::REG_CTRL3, 8'hc8);
    rd(urw_pkg::REG_DATA, 8'h5a);
    // Single wire direction
    wr(urw_pkg::REG_CTRL1, 8'ha0);
    chk("txd_oe", txd_oe, 1'b0);
    wr(urw_pkg::REG_CTRL3, 8'h20);
    chk("txd_oe", txd_oe, 1'b1);
    @(posedge sys_clk) i_rem.line <= 1'b1;
    wr(urw_pkg::REG_CTRL1, 8'h00);
    $display("test loop done");
    // Stop: edge still wakes, write one clears
    wr(urw_pkg::REG_BAUD_HI, 8'h40);
    wr(urw_pkg::REG_STAT2, 8'hc0);
    @(posedge sys_clk) {stop_mode, i_rem.line} <= 2'b10;
    repeat (8) @(posedge sys_clk);
    chk("stop_wake", stop_wake, 1'b1);
    wr(urw_pkg::REG_STAT2, 8'h40);
    chk("stop_wake", stop_wake, 1'b0);
    @(posedge sys_clk) {stop_mode, i_rem.line} <= 2'b01;
    $display("test stop done");
    // Idle-line wakeup: sleeping receiver drops the character, no idle flag
    bits(2);
    wr(urw_pkg::REG_CTRL2, 8'h06);
    i_rem.send(8'h12);
    bits(12);
    rd(urw_pkg::REG_CTRL2, 8'h04);
    rd(urw_pkg::REG_STAT1, 8'hc0);
    $display("test idle wakeup done");
    end_of_test();
  end
  // Hang guard, several times the expected run
  initial begin
    repeat (40000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end
endmodule // tb_top
